// ---- verilog/ar_pkg.sv ----
// Package for the auto-reclose control block: register map, field
// positions, reset values, timing constants, state and pin carriers.
// Assumes a 25 MHz system clock and a plain strobe register port.
package ar_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS       = 1_000_000;          // 1 ms tick
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int SUP_MARGIN_MS = 150;                // close supervision

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_SHOT  = 8'h04;
    localparam logic [7:0] A_DEAD  = 8'h08;
    localparam logic [7:0] A_RECL  = 8'h0C;
    localparam logic [7:0] A_PULSE = 8'h10;
    localparam logic [7:0] A_INHIB = 8'h14;
    localparam logic [7:0] A_BFDLY = 8'h18;
    localparam logic [7:0] A_STAT  = 8'h1C;
    localparam logic [7:0] A_IRQS  = 8'h20;
    localparam logic [7:0] A_IRQM  = 8'h24;

    // CTRL bits
    localparam int C_BFSUP  = 0;   // breaker-faulty supervision on
    localparam int C_BLKEN  = 1;   // block via input enabled
    localparam int C_DEADCB = 2;   // 1: dead time on breaker open
    localparam int C_FAST   = 3;   // block fast trip after first trip
    localparam int C_RST    = 4;   // write one: lockout reset command
    // SHOT fields
    localparam int S_MAX = 0;      // [2:0] shots allowed
    localparam int S_MA  = 4;      // [7:4] start A mask, shot 4..1
    localparam int S_MB  = 8;      // [11:8] start B mask, shot 4..1

    // Reset values
    localparam logic [3:0]  CTL_RST   = 4'h5;
    localparam logic [2:0]  MAX_RST   = 3'h4;
    localparam logic [3:0]  MSK_RST   = 4'hF;
    localparam logic [15:0] DEAD_RST  = 16'h01F4;
    localparam logic [15:0] RECL_RST  = 16'h0BB8;
    localparam logic [15:0] PULSE_RST = 16'h0064;
    localparam logic [15:0] INHIB_RST = 16'h0BB8;
    localparam logic [15:0] BFDLY_RST = 16'h0064;

    // Interrupt event bits
    localparam int EV_LOCK  = 0;
    localparam int EV_FINAL = 1;
    localparam int EV_SUCC  = 2;
    localparam int EV_ALARM = 3;
    localparam int NEV      = 4;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_TRIP  = 6'h02,
        ST_DEAD  = 6'h04,
        ST_CLOSE = 6'h08,
        ST_RECL  = 6'h10,
        ST_LOCK  = 6'h20
    } ar_state_t;

    typedef struct packed {
        logic cb_closed;          // breaker auxiliary, closed
        logic prot_trip;          // internal protection initiate
        logic ext_start_a;
        logic ext_start_b;
        logic breaker_faulty_in;
        logic ext_block;
        logic manual_close;
        logic roll_limit;         // rolling demand count reached
        logic conflict;
    } ar_in_t;

    typedef struct packed {
        logic in_progress;
        logic final_trip;
        logic lockout;
        logic blocked;
        logic success;
        logic close_cmd;
        logic fast_block;
        logic cb_alarm;
    } ar_out_t;

endpackage

// ---- verilog/ar_ctrl.sv ----
// Auto-reclose control block: input capture, reclose sequencer,
// status outputs, register port and interrupt.
// Assumes pins synchronous to clk; register master never waits.
`timescale 1ns/100ps

module ar_ctrl #(
    parameter int TICK_CYC = ar_pkg::TICK_CYC    // clocks per ms
) (
    input  wire logic          clk,      // 25 MHz system clock
    input  wire logic          rst_n,    // async reset, active low
    input  wire logic          ce,       // clock enable, freezes all
    input  wire logic [7:0]    addr,     // register byte address
    input  wire logic [31:0]   wdata,    // write data
    input  wire logic          wr,       // write strobe
    input  wire logic          rd,       // read strobe
    output logic [31:0]        rdata,    // read data, cycle after rd
    input  ar_pkg::ar_in_t     pins,     // logic inputs
    output ar_pkg::ar_out_t    stat,     // status and close outputs
    output logic               irq       // level interrupt
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (TICK_CYC < 1 || TICK_CYC > 65536) begin : g_chk
        $error("TICK_CYC out of range");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ar_pkg::ar_in_t    s1;
        ar_pkg::ar_in_t    s2;
        logic [15:0]       tick;
        logic              tk;
        ar_pkg::ar_state_t st;
        logic [2:0]        shot;
        logic [15:0]       tmr;
        logic [15:0]       bft;
        logic [15:0]       inh;
        logic              inh_on;
        logic              rcmd;
        ar_pkg::ar_out_t   o;
        logic [3:0]        ctl;
        logic [2:0]        maxs;
        logic [3:0]        mska;
        logic [3:0]        mskb;
        logic [15:0]       dead;
        logic [15:0]       recl;
        logic [15:0]       pulse;
        logic [15:0]       inhib;
        logic [15:0]       bfdly;
        logic [3:0]        ist;
        logic [3:0]        imsk;
        logic [31:0]       rdata;
    } ar_st_t;

    localparam ar_st_t RST = '{
        st:    ar_pkg::ST_IDLE,
        ctl:   ar_pkg::CTL_RST,
        maxs:  ar_pkg::MAX_RST,
        mska:  ar_pkg::MSK_RST,
        mskb:  ar_pkg::MSK_RST,
        dead:  ar_pkg::DEAD_RST,
        recl:  ar_pkg::RECL_RST,
        pulse: ar_pkg::PULSE_RST,
        inhib: ar_pkg::INHIB_RST,
        bfdly: ar_pkg::BFDLY_RST,
        default: '0
    };

    ar_st_t q;
    ar_st_t d;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        ar_pkg::ar_in_t  i;
        logic            go;
        logic            permit;
        logic            ext_blk;
        logic            int_blk;
        logic            inh_done;
        logic            dead_go;
        logic            lock;
        logic [3:0]      ev;
        logic [3:0]      clr;
        i        = q.s2;
        go       = 1'b0;
        permit   = 1'b0;
        ext_blk  = 1'b0;
        int_blk  = 1'b0;
        inh_done = 1'b0;
        dead_go  = 1'b0;
        lock     = 1'b0;
        ev       = '0;
        clr      = '0;
        d        = q;
        // Two-stage capture; first stage feeds only the second
        d.s1 = pins;
        d.s2 = q.s1;
        // Millisecond tick shared by every timer
        d.tk = 1'b0;
        if (q.tick == 16'(TICK_CYC - 1)) begin
            d.tick = '0;
            d.tk   = 1'b1;
        end else begin
            d.tick = q.tick + 16'h0001;
        end
        if (q.tk && q.tmr != 16'hFFFF) begin
            d.tmr = q.tmr + 16'h0001;
        end
        // Start inputs are trip-set timer outputs upstream
        go     = i.prot_trip | i.ext_start_a | i.ext_start_b;
        permit = i.prot_trip
               | (i.ext_start_a & q.mska[q.shot[1:0]])
               | (i.ext_start_b & q.mskb[q.shot[1:0]]);
        ext_blk = q.ctl[ar_pkg::C_BLKEN] & i.ext_block;
        int_blk = q.o.final_trip | i.roll_limit | i.conflict;
        // Faulty supervision timer runs while the fault is shown
        if (!i.breaker_faulty_in) begin
            d.bft = '0;
        end else if (q.tk && q.bft != 16'hFFFF) begin
            d.bft = q.bft + 16'h0001;
        end
        // Manual close arms the inhibit window
        inh_done = q.inh_on && q.inh >= q.inhib;
        if (i.manual_close) begin
            d.inh_on = 1'b1;
            d.inh    = '0;
        end else if (inh_done) begin
            d.inh_on = 1'b0;
        end else if (q.inh_on && q.tk) begin
            d.inh = q.inh + 16'h0001;
        end
        d.rcmd = 1'b0;
        // Sequencer
        case (q.st)
            ar_pkg::ST_IDLE: begin
                if (go && permit && !ext_blk && !int_blk
                    && !q.inh_on) begin
                    d.st            = ar_pkg::ST_TRIP;
                    d.o.in_progress = 1'b1;
                    d.o.success     = 1'b0;
                    d.shot          = '0;
                end
            end
            ar_pkg::ST_TRIP: begin
                dead_go = q.ctl[ar_pkg::C_DEADCB] ? !i.cb_closed
                                                  : !go;
                if (ext_blk || int_blk) begin
                    lock = 1'b1;
                end else if (dead_go) begin
                    d.st  = ar_pkg::ST_DEAD;
                    d.tmr = '0;
                end
            end
            ar_pkg::ST_DEAD: begin
                if (ext_blk || int_blk) begin
                    lock = 1'b1;
                end else if (q.tmr >= q.dead) begin
                    // Faulty breaker: wait out the delay, then give up
                    if (q.ctl[ar_pkg::C_BFSUP] && i.breaker_faulty_in) begin
                        if (q.bft >= q.bfdly) begin
                            lock = 1'b1;
                        end
                    end else begin
                        d.st          = ar_pkg::ST_CLOSE;
                        d.tmr         = '0;
                        d.o.close_cmd = 1'b1;
                    end
                end
            end
            ar_pkg::ST_CLOSE: begin
                d.o.close_cmd = q.tmr < q.pulse;
                if (i.cb_closed) begin
                    d.st          = ar_pkg::ST_RECL;
                    d.tmr         = '0;
                    d.o.close_cmd = 1'b0;
                    d.shot        = q.shot + 3'h1;
                end else if ({1'b0, q.tmr} >= {1'b0, q.pulse}
                             + 17'(ar_pkg::SUP_MARGIN_MS)) begin
                    lock              = 1'b1;
                    d.o.cb_alarm      = 1'b1;
                    ev[ar_pkg::EV_ALARM] = 1'b1;
                end
            end
            ar_pkg::ST_RECL: begin
                if (go) begin
                    if (q.shot >= q.maxs || !permit) begin
                        lock               = 1'b1;
                        d.o.final_trip     = 1'b1;
                        ev[ar_pkg::EV_FINAL] = 1'b1;
                    end else begin
                        d.st = ar_pkg::ST_TRIP;
                    end
                end else if (q.tmr >= q.recl) begin
                    d.st            = ar_pkg::ST_IDLE;
                    d.o.in_progress = 1'b0;
                    d.o.success     = 1'b1;
                    d.shot          = '0;
                    ev[ar_pkg::EV_SUCC] = 1'b1;
                end
            end
            ar_pkg::ST_LOCK: begin
                // Leave only by reset command or inhibit expiry
                if (q.rcmd || inh_done) begin
                    d.st     = ar_pkg::ST_IDLE;
                    d.shot   = '0;
                    d.o.cb_alarm = 1'b0;
                end
            end
            default: begin
                d.st = ar_pkg::ST_IDLE;
            end
        endcase
        if (lock) begin
            d.st            = ar_pkg::ST_LOCK;
            d.o.in_progress = 1'b0;
            d.o.close_cmd   = 1'b0;
            ev[ar_pkg::EV_LOCK] = 1'b1;
        end
        // Final trip held until reset or manual close plus inhibit
        if ((q.rcmd || inh_done) && !lock) begin
            d.o.final_trip = 1'b0;
        end
        d.o.lockout = (d.st == ar_pkg::ST_LOCK) | i.roll_limit
                    | i.conflict;
        d.o.blocked = ext_blk;
        d.o.fast_block = q.ctl[ar_pkg::C_FAST]
                       & (d.st != ar_pkg::ST_IDLE)
                       & (d.st != ar_pkg::ST_LOCK);
        // Register writes
        if (wr) begin
            case (addr)
                ar_pkg::A_CTRL: begin
                    d.ctl  = wdata[3:0];
                    d.rcmd = wdata[ar_pkg::C_RST];
                end
                ar_pkg::A_SHOT: begin
                    d.maxs = wdata[ar_pkg::S_MAX +: 3];
                    d.mska = wdata[ar_pkg::S_MA +: 4];
                    d.mskb = wdata[ar_pkg::S_MB +: 4];
                end
                ar_pkg::A_DEAD:  d.dead  = wdata[15:0];
                ar_pkg::A_RECL:  d.recl  = wdata[15:0];
                ar_pkg::A_PULSE: d.pulse = wdata[15:0];
                ar_pkg::A_INHIB: d.inhib = wdata[15:0];
                ar_pkg::A_BFDLY: d.bfdly = wdata[15:0];
                ar_pkg::A_IRQS:  clr     = wdata[3:0];
                ar_pkg::A_IRQM:  d.imsk  = wdata[3:0];
                default: begin
                end
            endcase
        end
        // Sticky events; a new event beats a same-cycle clear
        d.ist = (q.ist & ~clr) | ev;
        // Read data valid only in the cycle after the strobe
        d.rdata = '0;
        if (rd) begin
            case (addr)
                ar_pkg::A_CTRL:  d.rdata = {28'h0000000, q.ctl};
                ar_pkg::A_SHOT:  d.rdata = {20'h00000, q.mskb, q.mska,
                                            1'b0, q.maxs};
                ar_pkg::A_DEAD:  d.rdata = {16'h0000, q.dead};
                ar_pkg::A_RECL:  d.rdata = {16'h0000, q.recl};
                ar_pkg::A_PULSE: d.rdata = {16'h0000, q.pulse};
                ar_pkg::A_INHIB: d.rdata = {16'h0000, q.inhib};
                ar_pkg::A_BFDLY: d.rdata = {16'h0000, q.bfdly};
                ar_pkg::A_STAT:  d.rdata = {15'h0000, q.shot, q.st, q.o};
                ar_pkg::A_IRQS:  d.rdata = {28'h0000000, q.ist};
                ar_pkg::A_IRQM:  d.rdata = {28'h0000000, q.imsk};
                default:         d.rdata = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Reset returns idle, timers and shot count cleared
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // rdata and stat straight from flip-flops; irq is a level ORed from the masked flags
    assign rdata = q.rdata;
    assign stat  = q.o;
    assign irq   = |(q.ist & q.imsk);

endmodule

// ---- tb/ar_ctrl_asserts.sv ----
// Port checker for ar_ctrl, bound into every instance.
// Assumes a 5 ms close pulse; bench ce pauses move no pin.
`timescale 1ns/100ps
module ar_ctrl_asserts #(
    parameter int TICK_CYC = 4              // clocks per ms
) (
    input wire logic        clk,            // system clock
    input wire logic        rst_n,          // async reset
    input wire logic        ce,             // clock enable
    input wire logic [7:0]  addr,           // address
    input wire logic [31:0] wdata,          // write data
    input wire logic        wr,             // write strobe
    input wire logic        rd,             // read strobe
    input wire logic [31:0] rdata,          // read data
    input ar_pkg::ar_in_t   pins,           // logic inputs
    input ar_pkg::ar_out_t  stat,           // status outputs
    input wire logic        irq             // interrupt
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // Pulse, 150 ms margin and 5 ms slack, in clocks, plus 40 clocks
    localparam int CLOSE_MAX = 160 * TICK_CYC + 40;
    default clocking ck @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_close_on;
        $rose(stat.close_cmd);
    endsequence
    sequence s_close_off;
        !stat.close_cmd;
    endsequence
    property p_rst_clear;
        $rose(rst_n) |-> stat == '0;
    endproperty
    property p_rdata_idle;
        !$past(rd) |-> rdata == 32'h0;
    endproperty
    property p_close_prog;
        stat.close_cmd |-> stat.in_progress;
    endproperty
    // A close that never ends would hide a dead supervision timer
    property p_close_bound;
        s_close_on |-> ##[1:CLOSE_MAX] s_close_off;
    endproperty
    property p_alarm_lock;
        $rose(stat.cb_alarm) |-> stat.lockout && !stat.close_cmd;
    endproperty
    property p_final_lock;
        $rose(stat.final_trip) |-> stat.lockout && !stat.in_progress;
    endproperty
    property p_succ_end;
        $rose(stat.success) |-> $fell(stat.in_progress);
    endproperty
    property p_fast_prog;
        stat.fast_block |-> stat.in_progress;
    endproperty
    property p_int_block;
        (pins.conflict || pins.roll_limit) [*4] |-> stat.lockout;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("status not clear after reset");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without a read");
    a_close_prog: assert property (p_close_prog)
        else $error("close outside a cycle");
    a_close_bound: assert property (p_close_bound)
        else $error("close command too long");
    a_alarm_lock: assert property (p_alarm_lock)
        else $error("alarm without lockout");
    a_final_lock: assert property (p_final_lock)
        else $error("final trip without lockout");
    a_succ_end: assert property (p_succ_end)
        else $error("success not at cycle end");
    a_fast_prog: assert property (p_fast_prog)
        else $error("fast block outside a cycle");
    a_int_block: assert property (p_int_block)
        else $error("internal block not locked out");
endmodule

bind ar_ctrl ar_ctrl_asserts #(.TICK_CYC(TICK_CYC)) u_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pins(pins), .stat(stat),
    .irq(irq)
);

// ---- tb/ar_cb_model.sv ----
// Breaker model: opens on a trip, closes on a close command.
// Assumes commands are levels synchronous to clk.
`timescale 1ns/100ps
module ar_cb_model (
    input  wire logic clk,                  // system clock
    input  wire logic rst_n,                // async reset
    input  wire logic open_cmd,             // trip coil
    input  wire logic close_cmd,            // close coil
    input  wire logic stuck,                // refuses to close
    output logic      cb_closed             // auxiliary contact
);
    logic [2:0] op_q;
    logic [2:0] cl_q;
    // Three clocks of mechanism travel, so the block sees it late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_q <= 3'h0;
            cl_q <= 3'h0;
            cb_closed <= 1'b1;
        end else begin
            op_q <= {op_q[1:0], open_cmd};
            cl_q <= {cl_q[1:0], close_cmd & ~stuck};
            if (op_q[2]) begin
                cb_closed <= 1'b0;
            end else if (cl_q[2]) begin
                cb_closed <= 1'b1;
            end
        end
    end
endmodule

// ---- tb/ar_ctrl_tb_top.sv ----
// Bench for ar_ctrl: register tasks and reclose scenarios.
// Assumes the checker binds itself; obs bits: 9 irq, 8 breaker,
// 7 busy, 6 final, 5 lockout, 4 blocked, 3 success, 2 close, 1 fast,
// 0 alarm.
`timescale 1ns/100ps
module ar_ctrl_tb_top;
    logic            clk;
    logic            rst_n;
    logic            ce;
    logic [7:0]      addr;
    logic [31:0]     wdata;
    logic            wr;
    logic            rd;
    logic [31:0]     rdata;
    logic            irq;
    logic            cb;
    logic            stuck;
    ar_pkg::ar_in_t  pin;
    ar_pkg::ar_in_t  pin_w;
    ar_pkg::ar_out_t st;
    logic [9:0]      obs;
    logic [31:0]     rv [10];
    int              error_cnt;
    int              compares;
    // ------------------------------------------------------------
    // Design, breaker and clock
    // ------------------------------------------------------------
    // Breaker contact replaces the driven copy
    always_comb begin
        pin_w = pin;
        pin_w.cb_closed = cb;
    end
    assign obs = {irq, cb, st};
    ar_ctrl #(.TICK_CYC(4)) dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pins(pin_w), .stat(st), .irq(irq)
    );
    ar_cb_model u_cb (
        .clk(clk), .rst_n(rst_n), .stuck(stuck), .cb_closed(cb),
        .open_cmd(pin.prot_trip | pin.ext_start_a | pin.ext_start_b),
        .close_cmd(st.close_cmd | pin.manual_close)
    );
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Trailing edge keeps a next strobe out of this time step
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
        @(posedge clk);
    endtask
    // Sample at falling edges, clear of the design's updates
    task automatic wt(input int b, input logic v, input int n);
        int i;
        i = 0;
        @(negedge clk);
        while (obs[b] !== v && i < n) begin
            @(negedge clk);
            i++;
        end
        chk({31'h0, obs[b]}, {31'h0, v});
        @(posedge clk);
    endtask
    // Trip source held until the breaker has surely opened
    task automatic trip(input int k);
        pin.prot_trip <= (k == 0);
        pin.ext_start_a <= (k == 1);
        pin.ext_start_b <= (k == 2);
        repeat (8) @(posedge clk);
        pin.prot_trip <= 1'b0;
        pin.ext_start_a <= 1'b0;
        pin.ext_start_b <= 1'b0;
        @(posedge clk);
    endtask
    task automatic mclose(input int n);
        pin.manual_close <= 1'b1;
        repeat (2) @(posedge clk);
        pin.manual_close <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        error_cnt = 0;
        compares = 0;
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        pin = '0;
        stuck = 1'b0;
        ce = 1'b1;
        rv = '{32'h5, 32'hFF4, 32'h1F4, 32'hBB8, 32'h64, 32'hBB8,
               32'h64, 32'h100, 32'h0, 32'h0};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            rchk(8'(4 * i), rv[i]);
        end
        rchk(8'h28, 32'h0);
        // Short timers: dead 3, reclaim 20, pulse 5, inhibit 10 ms
        wreg(8'h08, 32'h3);
        wreg(8'h0C, 32'h14);
        wreg(8'h10, 32'h5);
        wreg(8'h14, 32'hA);
        wreg(8'h18, 32'h4);
        wreg(8'h04, 32'hEF2);
        wreg(8'h24, 32'hF);
        wreg(8'h00, 32'hF);
        rchk(8'h04, 32'hEF2);
        // Clock enable low: the write is lost, dead time stays 3 ms
        ce <= 1'b0;
        wreg(8'h08, 32'h7);
        ce <= 1'b1;
        rchk(8'h08, 32'h3);
        // One shot that holds, then its interrupt read and cleared
        trip(0);
        wt(7, 1'b1, 1);
        wt(1, 1'b1, 1);
        wt(2, 1'b1, 200);
        wt(3, 1'b1, 400);
        wt(7, 1'b0, 1);
        rchk(8'h20, 32'h4);
        wt(9, 1'b1, 1);
        wreg(8'h20, 32'h4);
        wt(9, 1'b0, 1);
        // Retrips in reclaim, second from start B, end in final trip
        for (int s = 0; s < 3; s++) begin
            trip((s == 1) ? 2 : 0);
            wt(3, 1'b0, 1);
            if (s < 2) begin
                wt(2, 1'b1, 200);
                wt(2, 1'b0, 100);
            end
        end
        wt(6, 1'b1, 50);
        wt(5, 1'b1, 1);
        rchk(8'h20, 32'h3);
        wreg(8'h24, 32'h0);
        wt(9, 1'b0, 1);
        wreg(8'h24, 32'hF);
        wt(9, 1'b1, 1);
        wreg(8'h20, 32'h3);
        wt(9, 1'b0, 1);
        trip(1);
        wt(7, 1'b0, 1);
        mclose(10);
        wt(6, 1'b1, 1);
        wt(6, 1'b0, 100);
        repeat (20) @(posedge clk);
        // Start B has shot 1 masked; A runs with dead on trip reset
        trip(2);
        wt(7, 1'b0, 1);
        mclose(60);
        wreg(8'h00, 32'hB);
        trip(1);
        wt(7, 1'b1, 1);
        wt(3, 1'b1, 600);
        wreg(8'h00, 32'hF);
        // Block input with its enable, then without
        pin.ext_block <= 1'b1;
        wt(4, 1'b1, 10);
        trip(0);
        wt(7, 1'b0, 1);
        pin.ext_block <= 1'b0;
        wt(4, 1'b0, 10);
        mclose(60);
        wreg(8'h00, 32'hD);
        pin.ext_block <= 1'b1;
        // Give the pin time to reach the output before looking
        repeat (4) @(posedge clk);
        wt(4, 1'b0, 1);
        pin.ext_block <= 1'b0;
        wreg(8'h00, 32'hF);
        wreg(8'h20, 32'hF);
        // Breaker never closes: supervision alarm, reset command
        stuck <= 1'b1;
        trip(0);
        wt(0, 1'b1, 800);
        wt(5, 1'b1, 1);
        rchk(8'h20, 32'h9);
        stuck <= 1'b0;
        wreg(8'h00, 32'h1F);
        wt(5, 1'b0, 10);
        mclose(60);
        // Faulty breaker at dead-time end locks out with no close
        pin.breaker_faulty_in <= 1'b1;
        trip(0);
        wt(5, 1'b1, 200);
        wt(8, 1'b0, 1);
        pin.breaker_faulty_in <= 1'b0;
        wreg(8'h00, 32'h1F);
        mclose(60);
        // Reset in mid-cycle returns idle with the shot count cleared
        trip(0);
        wt(7, 1'b1, 1);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wt(7, 1'b0, 1);
        rchk(8'h1C, 32'h100);
        // Conflict and demand limit each lock out while present
        for (int k = 0; k < 2; k++) begin
            pin.conflict <= (k == 0);
            pin.roll_limit <= (k == 1);
            wt(5, 1'b1, 10);
            pin.conflict <= 1'b0;
            pin.roll_limit <= 1'b0;
            wt(5, 1'b0, 10);
        end
        stop_test();
    end
    // Watchdog: the scenarios need well under 10000 clocks
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule
